// >>> pkg/tdsr_defines.vh
// Constants for the tile debug and status register bank.
// Assumes a word-indexed register port; indices are printed offsets.
`ifndef TDSR_DEFINES_VH
`define TDSR_DEFINES_VH
`define TDSR_IDX_RING_CELL    8'h09
`define TDSR_IDX_RING_WIRE    8'h0a
`define TDSR_IDX_MEM_SIZE     8'h0c
`define TDSR_IDX_SAVED_STATUS 8'h10
`define TDSR_IDX_SAVED_PC     8'h11
`define TDSR_IDX_SAVED_SP     8'h12
`define TDSR_IDX_THREAD_SEL   8'h13
`define TDSR_IDX_REG_SEL      8'h14
`define TDSR_IDX_ENTRY_CAUSE  8'h15
`define TDSR_RING_W           16
`define TDSR_STATUS_W         11
`define TDSR_STATUS_WR_MASK   11'h6df
`define TDSR_STATUS_ISSUE_BIT 8
`define TDSR_THREAD_W         8
`define TDSR_REG_W            5
`define TDSR_CAUSE_W          3
`define TDSR_CAUSE_RST        3'h0
`define TDSR_CAUSE_HOST       3'h1
`define TDSR_CAUSE_DEBUG_CALL_INSTR      3'h2
`define TDSR_CAUSE_IBREAK     3'h3
`define TDSR_CAUSE_DWATCH     3'h4
`define TDSR_CAUSE_RWATCH     3'h5
`define TDSR_MEM_SIZE_DEF     30'h00008000
`endif

// >>> src/tdsr_regs.v
// Tile debug and status register bank: ring counters, RAM size, debug entry state.
// Assumes a single-cycle processor-status access port on core_clk; ring
// oscillator clocks arrive as asynchronous levels and are synchronised here.
`timescale 1ns/10ps
`include "tdsr_defines.vh"

// Function
// (R1) The peripheral cell ring count reads as 16 bits with upper bits zero.
// (R2) The peripheral wire ring count reads as a separate 16-bit value at the next index.
// (R3) Ring counts survive system reset and start at zero only at power-up.
// (R4) Software reads a ring count only after the oscillator has been stopped ten cycles.
// (R5) The RAM size in bytes reads in bits 31:2 with bits 1:0 zero.
// (R6) Debug entry captures the thread status word with its five low flags.
// (R7) Captured bit 7 marks continuous issue and bit 6 marks a paused thread.
// (R8) Bit 8 is read-only issue mode, bit 9 writable entry issue mode, bit 10 address space.
// (R9) Debug entry saves the 32-bit program counter, readable and writable.
// (R10) Debug entry saves the 32-bit stack pointer, readable and writable.
// (R11) An 8-bit thread selector chooses the thread for the register-fetch instruction.
// (R12) A 5-bit register selector gives the register-fetch instruction its index.
// (R13) A 3-bit cause code resets to zero, with codes one to five for the entry sources.
// (R14) A 2-bit field names the lowest firing break or watch unit, zero for host and call.
// (R15) An 8-bit field names the causing thread, zero for host requests.
// (R16) Debug-writable fields take writes only in debug mode; reserved bits read zero.
module tdsr_regs (
	input  wire        core_clk,
	input  wire        rstn,
	input  wire        ring_cell_osc,
	input  wire        ring_wire_osc,
	input  wire [29:0] mem_size_words,
	input  wire        debug_mode,
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [7:0]  reg_idx,
	input  wire [31:0] reg_wdata,
	output reg  [31:0] reg_rdata,
	output wire        reg_hit,
	input  wire        dbg_entry,
	input  wire [2:0]  dbg_entry_cause,
	input  wire [3:0]  dbg_unit_hits,
	input  wire [7:0]  dbg_entry_thread,
	input  wire [10:0] thread_status,
	input  wire [31:0] thread_pc,
	input  wire [31:0] thread_sp,
	input  wire        cur_issue_mode,
	output wire [7:0]  fetch_thread_sel,
	output wire [4:0]  fetch_reg_sel
);

	// Oscillator synchronisers and counters; no reset so values survive system reset
	reg [1:0]                 cell_sync_ff;
	reg [1:0]                 wire_sync_ff;
	reg                       cell_prev_ff;
	reg                       wire_prev_ff;
	reg [`TDSR_RING_W-1:0]    cell_cnt_ff = 16'h0000;
	reg [`TDSR_RING_W-1:0]    wire_cnt_ff = 16'h0000;

	// Debug entry state
	reg [`TDSR_STATUS_W-1:0]  status_ff;
	reg [31:0]                pc_ff;
	reg [31:0]                sp_ff;
	reg [`TDSR_THREAD_W-1:0]  thread_sel_ff;
	reg [`TDSR_REG_W-1:0]     reg_sel_ff;
	reg [`TDSR_CAUSE_W-1:0]   cause_ff;
	reg [1:0]                 unit_ff;
	reg [7:0]                 src_thread_ff;
	reg [1:0]                 nxt_unit;
	reg [31:0]                nxt_rdata;
	wire                      dwr;
	wire                      host_or_call;
	wire                      hw_trigger;

	// Debug-writable fields are guarded by debug mode
	assign dwr          = reg_wr & debug_mode; // R16
	assign host_or_call = (dbg_entry_cause == `TDSR_CAUSE_HOST) |
	                      (dbg_entry_cause == `TDSR_CAUSE_DEBUG_CALL_INSTR);
	assign hw_trigger   = (dbg_entry_cause == `TDSR_CAUSE_IBREAK) |
	                      (dbg_entry_cause == `TDSR_CAUSE_DWATCH) |
	                      (dbg_entry_cause == `TDSR_CAUSE_RWATCH);
	assign fetch_thread_sel = thread_sel_ff; // R11
	assign fetch_reg_sel    = reg_sel_ff; // R12
	assign reg_hit = (reg_idx == `TDSR_IDX_RING_CELL) | (reg_idx == `TDSR_IDX_RING_WIRE) |
	                 (reg_idx == `TDSR_IDX_MEM_SIZE) |
	                 ((reg_idx >= `TDSR_IDX_SAVED_STATUS) &&
	                  (reg_idx <= `TDSR_IDX_ENTRY_CAUSE));

	// Counting is on synchronised edges, so the value is only exact once the
	// oscillator is stopped; software waits before reading
	always @(posedge core_clk) begin
		cell_sync_ff <= {cell_sync_ff[0], ring_cell_osc};
		wire_sync_ff <= {wire_sync_ff[0], ring_wire_osc};
		cell_prev_ff <= cell_sync_ff[1];
		wire_prev_ff <= wire_sync_ff[1];
		if (cell_sync_ff[1] & ~cell_prev_ff)
			cell_cnt_ff <= cell_cnt_ff + 16'h0001; // R1 R3 R4
		if (wire_sync_ff[1] & ~wire_prev_ff)
			wire_cnt_ff <= wire_cnt_ff + 16'h0001; // R2 R3
	end

	// Lowest-numbered firing unit wins
	always @* begin
		nxt_unit = 2'h0;
		if (hw_trigger) begin
			if (dbg_unit_hits[0])
				nxt_unit = 2'h0;
			else if (dbg_unit_hits[1])
				nxt_unit = 2'h1;
			else if (dbg_unit_hits[2])
				nxt_unit = 2'h2;
			else if (dbg_unit_hits[3])
				nxt_unit = 2'h3; // R14
		end
	end

	// Capture on entry takes priority over a same-cycle software write
	always @(posedge core_clk) begin
		if (!rstn) begin
			status_ff     <= 11'h000;
			pc_ff         <= 32'h00000000;
			sp_ff         <= 32'h00000000;
			thread_sel_ff <= 8'h00;
			reg_sel_ff    <= 5'h00;
			cause_ff      <= `TDSR_CAUSE_RST; // R13
			unit_ff       <= 2'h0;
			src_thread_ff <= 8'h00;
		end else if (dbg_entry) begin
			status_ff     <= thread_status; // R6 R7 R8
			pc_ff         <= thread_pc; // R9
			sp_ff         <= thread_sp; // R10
			cause_ff      <= dbg_entry_cause; // R13
			unit_ff       <= host_or_call ? 2'h0 : nxt_unit; // R14
			src_thread_ff <= (dbg_entry_cause == `TDSR_CAUSE_HOST) ? 8'h00 :
			                 dbg_entry_thread; // R15
		end else if (dwr) begin
			case (reg_idx)
				`TDSR_IDX_SAVED_STATUS: status_ff <= (reg_wdata[10:0] & `TDSR_STATUS_WR_MASK) |
				                            (status_ff & ~`TDSR_STATUS_WR_MASK); // R8 R16
				`TDSR_IDX_SAVED_PC:     pc_ff <= reg_wdata; // R9
				`TDSR_IDX_SAVED_SP:     sp_ff <= reg_wdata; // R10
				`TDSR_IDX_THREAD_SEL:   thread_sel_ff <= reg_wdata[7:0]; // R11
				`TDSR_IDX_REG_SEL:      reg_sel_ff <= reg_wdata[4:0]; // R12
				`TDSR_IDX_ENTRY_CAUSE: begin
					cause_ff      <= reg_wdata[2:0];
					src_thread_ff <= reg_wdata[15:8];
					unit_ff       <= reg_wdata[17:16];
				end
				default: ;
			endcase
		end
	end

	// Read mux; reserved bits and unmapped indices read zero
	always @* begin
		nxt_rdata = 32'h00000000;
		case (reg_idx)
			`TDSR_IDX_RING_CELL:    nxt_rdata = {16'h0000, cell_cnt_ff}; // R1
			`TDSR_IDX_RING_WIRE:    nxt_rdata = {16'h0000, wire_cnt_ff}; // R2
			`TDSR_IDX_MEM_SIZE:     nxt_rdata = {mem_size_words, 2'b00}; // R5
			`TDSR_IDX_SAVED_STATUS: nxt_rdata = {21'h000000, status_ff[10:9], cur_issue_mode,
			                                     status_ff[7:6], 1'b0, status_ff[4:0]}; // R8
			`TDSR_IDX_SAVED_PC:     nxt_rdata = pc_ff;
			`TDSR_IDX_SAVED_SP:     nxt_rdata = sp_ff;
			`TDSR_IDX_THREAD_SEL:   nxt_rdata = {24'h000000, thread_sel_ff};
			`TDSR_IDX_REG_SEL:      nxt_rdata = {27'h0000000, reg_sel_ff};
			`TDSR_IDX_ENTRY_CAUSE:  nxt_rdata = {14'h0000, unit_ff, src_thread_ff,
			                                     5'h00, cause_ff}; // R16
			default:                nxt_rdata = 32'h00000000;
		endcase
	end

	// Registered read data, cleared by reset and otherwise updated only on a read strobe
	always @(posedge core_clk) begin
		if (!rstn)
			reg_rdata <= 32'h00000000;
		else if (reg_rd)
			reg_rdata <= nxt_rdata;
	end

endmodule

// >>> tb/tdsr_chk.sv
// Port checker for the tile debug and status register bank.
// Assumes reads answer one cycle after the strobe.
`timescale 1ns/10ps
module tdsr_chk (
	input wire        core_clk, rstn, reg_rd, reg_wr, debug_mode, reg_hit,
	input wire [7:0]  reg_idx, fetch_thread_sel,
	input wire [4:0]  fetch_reg_sel,
	input wire [29:0] mem_size_words,
	input wire [31:0] reg_wdata, reg_rdata
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// Read and write strobes at one index; answers land on the next edge
	sequence rd_at(logic [7:0] i);
		reg_rd && reg_idx == i;
	endsequence
	sequence wr_at(logic [7:0] i);
		reg_wr && debug_mode && reg_idx == i;
	endsequence
	cell_upper_a: assert property (rd_at(8'h09) |=> reg_rdata[31:16] == 16'h0)
		else $error("cell count upper bits set");
	wire_upper_a: assert property (rd_at(8'h0a) |=> reg_rdata[31:16] == 16'h0)
		else $error("wire count upper bits set");
	mem_size_a: assert property (rd_at(8'h0c) |=> reg_rdata == {$past(mem_size_words), 2'b00})
		else $error("memory size read wrong");
	status_rsv_a: assert property (rd_at(8'h10) |=> !reg_rdata[31:11] && !reg_rdata[5])
		else $error("status reserved bits set");
	cause_rsv_a: assert property (rd_at(8'h15) |=> !reg_rdata[31:18] && !reg_rdata[7:3])
		else $error("cause reserved bits set");
	thread_sel_a: assert property (wr_at(8'h13) |=> fetch_thread_sel == ($past(reg_wdata) & 32'hff))
		else $error("thread selector not written");
	reg_sel_a: assert property (wr_at(8'h14) |=> fetch_reg_sel == ($past(reg_wdata) & 32'h1f))
		else $error("register selector not written");
	wr_locked_a: assert property (reg_wr && !debug_mode |=> $stable(fetch_thread_sel) && $stable(fetch_reg_sel))
		else $error("selector changed outside debug");
	unmapped_a: assert property (reg_rd && !reg_hit |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
endmodule
bind tdsr_regs tdsr_chk tdsr_chk_i (.core_clk, .rstn, .reg_rd, .reg_wr, .debug_mode, .reg_hit,
	.reg_idx, .fetch_thread_sel, .fetch_reg_sel, .mem_size_words, .reg_wdata, .reg_rdata);

// >>> tb/tdsr_osc_model.sv
// Ring oscillator stand-in: while run is high it makes rising edges, then rests low.
// Assumes the bench holds run for whole periods of eight cycles.
`timescale 1ns/10ps
module tdsr_osc_model (
	input  wire  core_clk,
	input  wire  run,
	output logic cell_osc,
	output logic wire_osc
);
	logic [9:0] ph_ff = 10'h0;
	// Rest clears the phase so no stray edge follows a stop
	always @(posedge core_clk) ph_ff <= run ? ph_ff + 10'h1 : 10'h0;
	assign cell_osc = ph_ff[1];
	assign wire_osc = ph_ff[2];
endmodule

// >>> tb/tdsr_regs_tb.sv
// Bench for the register bank: drives the access port, entry inputs and oscillators.
// Assumes writes need debug mode and reads answer one cycle after the strobe.
`timescale 1ns/10ps
`include "tdsr_defines.vh"
module tdsr_regs_tb;
	logic core_clk = 0, rstn = 0, debug_mode = 0, reg_wr = 0, reg_rd = 0, dbg_entry = 0;
	logic cur_issue_mode = 0, run = 0, cell_osc, wire_osc, reg_hit;
	logic [7:0]  reg_idx = 8'h0, dbg_entry_thread = 8'h0, fetch_thread_sel;
	logic [2:0]  dbg_entry_cause = 3'h0;
	logic [3:0]  dbg_unit_hits = 4'h0;
	logic [4:0]  fetch_reg_sel;
	logic [10:0] thread_status = 11'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, thread_pc = 32'h0, thread_sp = 32'h0;
	int fail_count = 0, check_count = 0, cyc = 0;
	tdsr_regs tdsr_regs_i (.core_clk, .rstn, .ring_cell_osc(cell_osc), .ring_wire_osc(wire_osc),
		.mem_size_words(`TDSR_MEM_SIZE_DEF), .debug_mode, .reg_wr, .reg_rd, .reg_idx,
		.reg_wdata, .reg_rdata, .reg_hit, .dbg_entry, .dbg_entry_cause, .dbg_unit_hits,
		.dbg_entry_thread, .thread_status, .thread_pc, .thread_sp, .cur_issue_mode,
		.fetch_thread_sel, .fetch_reg_sel);
	tdsr_osc_model tdsr_osc_model_i (.core_clk, .run, .cell_osc, .wire_osc);
	always #5 core_clk = ~core_clk;
	// Cut a hang short well past the expected run length
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			report_and_stop;
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task rd(input logic [7:0] i, input logic [31:0] e);
		@(posedge core_clk) {reg_rd, reg_idx} <= {1'b1, i};
		@(posedge core_clk) reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	task wr(input logic [7:0] i, input logic [31:0] d);
		@(posedge core_clk) {reg_wr, reg_idx, reg_wdata} <= {1'b1, i, d};
		@(posedge core_clk) reg_wr <= 1'b0;
	endtask
	task t_access;
		rd(8'h15, 32'h0);
		rd(8'h0c, {`TDSR_MEM_SIZE_DEF, 2'b00});
		rd(8'h0b, 32'h0);
		chk({31'h0, reg_hit}, 32'h0);
		$display("access test done");
	endtask
	task t_entry;
		for (int c = 1; c <= 5; c++) begin
			@(posedge core_clk) {dbg_entry, dbg_entry_cause, dbg_entry_thread} <= {1'b1, 3'(c), 8'(8'h20 + c)};
			{dbg_unit_hits, thread_status, cur_issue_mode} <= {4'b0110, 11'h7ff, 1'b1};
			{thread_pc, thread_sp} <= {32'hc0de0000 + c, 32'h5ac00000 - c};
			@(posedge core_clk) dbg_entry <= 1'b0;
			rd(8'h15, {14'h0, c > 2 ? 2'h1 : 2'h0, c == 1 ? 8'h0 : 8'(8'h20 + c), 5'h0, 3'(c)});
			rd(8'h10, 32'h7df);
			rd(8'h11, 32'hc0de0000 + c);
			rd(8'h12, 32'h5ac00000 - c);
		end
		$display("entry test done");
	endtask
	task t_write;
		wr(8'h13, 32'h77);
		chk({24'h0, fetch_thread_sel}, 32'h0);
		debug_mode <= 1'b1;
		wr(8'h13, 32'hffffffa5);
		rd(8'h13, 32'ha5);
		chk({24'h0, fetch_thread_sel}, 32'ha5);
		wr(8'h14, 32'hffffffff);
		rd(8'h14, 32'h1f);
		chk({27'h0, fetch_reg_sel}, 32'h1f);
		wr(8'h10, 32'h0);
		rd(8'h10, 32'h100);
		chk({31'h0, reg_hit}, 32'h1);
		wr(8'h12, 32'h12345678);
		rd(8'h12, 32'h12345678);
		wr(8'h0c, 32'h0);
		rd(8'h0c, {`TDSR_MEM_SIZE_DEF, 2'b00});
		$display("write test done");
	endtask
	task t_ring;
		@(posedge core_clk) run <= 1'b1;
		repeat (32) @(posedge core_clk);
		run <= 1'b0;
		repeat (12) @(posedge core_clk);
		rd(8'h09, 32'h8);
		rd(8'h0a, 32'h4);
		rstn <= 1'b0;
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		rd(8'h09, 32'h8);
		rd(8'h0a, 32'h4);
		$display("ring test done");
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		t_access;
		t_entry;
		t_write;
		t_ring;
		report_and_stop;
	end
endmodule
